/* File: bench/internal_osc_clock_control_test.sv */
// self-checking bench for the internal oscillator control block
// assumes ioc_top with sfr strobes; inputs driven at the falling edge
`timescale 1ns/1ps
`include "ioc_map.svh"
module internal_osc_clock_control_test;
  logic clk = 0;
  logic resetn = 0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 0;
  logic sfr_rd = 0;
  logic [7:0] sfr_rdata;
  logic usb_nonidle = 0;
  logic vbus_level = 0;
  // polarity differs from vbus so the oscillator is not woken at once
  logic bus_power_polarity_sel = 1;
  logic clk_recovery_en = 0;
  logic [4:0] recovery_trim = 5'h00;
  logic src_load = 0;
  logic [1:0] core_src_req = 2'h0;
  logic [1:0] bus_src_req = 2'h0;
  logic ext_osc_in = 0;
  logic mult_in = 0;
  logic osc_run;
  logic [4:0] period_trim_value;
  logic core_clock_tick;
  logic bus_function_clock_tick;
  logic resume_irq;
  logic trim_modified;
  int err_total = 0;
  int total_checks = 0;
  int nc;
  int nb;

  always #50 clk = ~clk;

  ioc_top dut (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .usb_nonidle(usb_nonidle),
    .vbus_level(vbus_level),
    .bus_power_polarity_sel(bus_power_polarity_sel),
    .clk_recovery_en(clk_recovery_en), .recovery_trim(recovery_trim),
    .src_load(src_load), .core_src_req(core_src_req),
    .bus_src_req(bus_src_req), .ext_osc_in(ext_osc_in),
    .mult_in(mult_in), .osc_run(osc_run),
    .period_trim_value(period_trim_value),
    .core_clock_tick(core_clock_tick),
    .bus_function_clock_tick(bus_function_clock_tick),
    .resume_irq(resume_irq), .trim_modified(trim_modified));

  task summarize;
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    @(negedge clk);
    sfr_wr = 0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1;
    @(negedge clk);
    sfr_rd = 0;
    chk(sfr_rdata, exp);
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // gap in cycles between two core ticks, after the new divide is applied
  task period(output int g);
    int k;
    g = 0;
    for (k = 0; k < 3; k++) begin
      g = 0;
      do begin
        @(negedge clk);
        g++;
      end while (core_clock_tick !== 1'b1 && g < 40);
    end
  endtask

  // ten rising edges on the chosen source pin while ticks are counted
  task run_src(input bit use_mult);
    int i;
    nc = 0;
    nb = 0;
    for (i = 0; i < 48; i++) begin
      @(negedge clk);
      if (use_mult) mult_in = (i < 40) && (i % 4 < 2);
      else ext_osc_in = (i < 40) && (i % 4 < 2);
      if (core_clock_tick === 1'b1) nc++;
      if (bus_function_clock_tick === 1'b1) nb++;
    end
  endtask

  task load_src(input logic [1:0] c, input logic [1:0] b);
    @(negedge clk);
    core_src_req = c;
    bus_src_req = b;
    src_load = 1;
    @(negedge clk);
    src_load = 0;
  endtask

  task wait_run(output int n);
    n = 0;
    while (osc_run !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
  endtask

  initial begin
    int g;
    int c;
    repeat (3) @(negedge clk);
    resetn = 1;
    chk(period_trim_value, 8'h10);
    rd(`IOC_CTRL_ADDR, 8'h80);
    rd(`IOC_TRIM_ADDR, 8'h10);
    cyc(12);
    rd(`IOC_CTRL_ADDR, 8'hC0);
    period(g);
    chk(g, 8);
    for (c = 0; c < 4; c++) begin
      wr(`IOC_CTRL_ADDR, 8'h9C | c);
      rd(`IOC_CTRL_ADDR, 8'hC0 | c);
      period(g);
      chk(g, 8 >> c);
    end
    // bus clock taken from the oscillator only while trim is factory
    load_src(2'h0, 2'h0);
    cyc(4);
    run_src(0);
    chk(nb, 48);
    load_src(2'h1, 2'h1);
    run_src(0);
    chk(nc >= 8 && nc <= 11, 1);
    chk(nb >= 8 && nb <= 11, 1);
    load_src(2'h2, 2'h2);
    run_src(1);
    chk(nc >= 4 && nc <= 6, 1);
    chk(nb >= 8 && nb <= 11, 1);
    // the spare source code must give no clock at all
    load_src(2'h3, 2'h3);
    run_src(0);
    chk(nc, 0);
    chk(nb, 0);
    // bus clock leaves the oscillator before the trim is changed
    load_src(2'h0, 2'h1);
    wr(`IOC_TRIM_ADDR, 8'hF5);
    chk(period_trim_value, 8'h15);
    chk(trim_modified, 1);
    rd(`IOC_TRIM_ADDR, 8'h15);
    rd(`IOC_CTRL_ADDR, 8'h83);
    cyc(12);
    rd(`IOC_CTRL_ADDR, 8'hC3);
    wr(`IOC_TRIM_ADDR, 8'h1F);
    chk(period_trim_value, 8'h1F);
    wr(`IOC_TRIM_ADDR, 8'h00);
    chk(period_trim_value, 8'h00);
    recovery_trim = 5'h03;
    clk_recovery_en = 1;
    cyc(3);
    chk(period_trim_value, 8'h03);
    wr(`IOC_TRIM_ADDR, 8'h07);
    cyc(2);
    chk(period_trim_value, 8'h03);
    clk_recovery_en = 0;
    wr(`IOC_CTRL_ADDR, 8'hA3);
    cyc(2);
    chk(osc_run, 0);
    run_src(0);
    chk(nc, 0);
    usb_nonidle = 1;
    g = 0;
    while (resume_irq !== 1'b1 && g < 8) begin
      @(negedge clk);
      g++;
    end
    chk(resume_irq, 1);
    chk(osc_run, 1);
    usb_nonidle = 0;
    wr(`IOC_CTRL_ADDR, 8'hA3);
    cyc(2);
    chk(osc_run, 0);
    vbus_level = 1;
    wait_run(g);
    chk(osc_run, 1);
    vbus_level = 0;
    wr(`IOC_CTRL_ADDR, 8'h03);
    cyc(2);
    chk(osc_run, 0);
    run_src(0);
    chk(nc, 0);
    rd(`IOC_CTRL_ADDR, 8'h03);
    wr(`IOC_CTRL_ADDR, 8'h83);
    wait_run(g);
    chk(osc_run, 1);
    wr(`IOC_TRIM_ADDR, 8'h05);
    resetn = 0;
    cyc(3);
    resetn = 1;
    chk(period_trim_value, 8'h10);
    chk(trim_modified, 0);
    rd(`IOC_CTRL_ADDR, 8'h80);
    summarize;
  end

  // the tests need about 470 cycles; allow some thirty times that
  initial begin
    #1_500_000;
    err_total++;
    summarize;
  end
endmodule

/* File: logic/ioc_clkdiv.sv */
// core clock divider: one tick per divided oscillator period
// assumes sel may change at any cycle; it is applied at a period end or while the oscillator is stopped
`timescale 1ns/1ps
module ioc_clkdiv (
  input wire logic clk,
  input wire logic resetn,
  ioc_div_if.div dif
);
  logic [2:0] cnt_q;
  ioc_pkg::ioc_div_e sel_q;
  logic tick_q;
  logic wrap;

  function automatic logic [2:0] last_count(ioc_pkg::ioc_div_e s);
    unique case (s)
      ioc_pkg::IOC_DIV8: last_count = 3'h7; // [RL4]
      ioc_pkg::IOC_DIV4: last_count = 3'h3; // [RL4]
      ioc_pkg::IOC_DIV2: last_count = 3'h1; // [RL4]
      ioc_pkg::IOC_DIV1: last_count = 3'h0; // [RL4]
    endcase
  endfunction

  assign wrap = cnt_q == last_count(sel_q);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 3'h0;
    end else if (!dif.run || wrap) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // new divide at a period end or while stopped, so no period is ever cut short
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_q <= ioc_pkg::IOC_DIV8;
    end else if (!dif.run || wrap) begin
      sel_q <= dif.sel; // [RL18]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= dif.run && wrap;
    end
  end

  assign dif.tick = tick_q;
  assign dif.applied = sel_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_DIV8_SPACING: assert property ( // [RL18]
    tick_q && sel_q == ioc_pkg::IOC_DIV8 && dif.run |=>
      !tick_q [*7])
    else $error("divide by 8 tick spacing too short");
  AST_DIV1_EVERY: assert property ( // [RL4]
    dif.run && $past(dif.run) && sel_q == ioc_pkg::IOC_DIV1 &&
      $past(sel_q) == ioc_pkg::IOC_DIV1 |=> tick_q)
    else $error("divide by 1 missed a tick");
endmodule

/* File: logic/ioc_div_if.sv */
// internal oscillator control: link between control and core clock divider
// assumes both ends share clk and resetn
`timescale 1ns/1ps
interface ioc_div_if;
  logic run;
  ioc_pkg::ioc_div_e sel;
  ioc_pkg::ioc_div_e applied;
  logic tick;
  modport ctrl (output run, output sel, input applied, input tick);
  modport div (input run, input sel, output applied, output tick);
endinterface

/* File: logic/ioc_map.svh */
// internal oscillator control: addresses, field positions, resets, timing
// assumes a 10 MHz clock with a period of 100 ns
`ifndef IOC_MAP_SVH
`define IOC_MAP_SVH
`define IOC_CTRL_ADDR 8'hB2
`define IOC_TRIM_ADDR 8'hB3
`define IOC_CTRL_RESET 8'h80
`define IOC_EN_BIT 7
`define IOC_RDY_BIT 6
`define IOC_SUSP_BIT 5
`define IOC_DIV_MSB 1
`define IOC_TRIM_MSB 4
`define IOC_TRIM_FACTORY 5'h10
`define IOC_CLK_PERIOD_NS 100
`define IOC_SETTLE_NS 1000
`define IOC_SETTLE_CYC \
  ((`IOC_SETTLE_NS + `IOC_CLK_PERIOD_NS - 1) / `IOC_CLK_PERIOD_NS)
`define IOC_SETTLE_W 4
`endif

/* File: logic/ioc_pkg.sv */
// internal oscillator control: shared types
// assumes ioc_map.svh carries all numeric constants
package ioc_pkg;
  typedef enum logic [1:0] {IOC_DIV8, IOC_DIV4, IOC_DIV2, IOC_DIV1} ioc_div_e;
  typedef enum logic [1:0] {IOC_SRC_INT, IOC_SRC_EXT, IOC_SRC_MULT} ioc_src_e;
  typedef enum logic [1:0] {IOC_OFF, IOC_SETTLE, IOC_READY, IOC_SUSP}
    ioc_state_e;
endpackage

/* File: logic/ioc_top.sv */
// internal oscillator control: registers, oscillator state, clock selects
// assumes sfr port on clk; usb, vbus and clock pins are asynchronous
//
// Function
// [RL1] after reset the core clock comes from the internal oscillator
// [RL2] core clock source: internal, external, or 4x multiplier halved
// [RL3] bus function clock source: internal, external, or 4x multiplier
// [RL4] divide field codes 00..11 give divide by 8, 4, 2, 1
// [RL5] control register resets to 80: enabled, divide by 8
// [RL6] five-bit trim in bits 4..0 sets the oscillator period
// [RL7] every reset reloads the trim with its factory value
// [RL8] software must not use internal clock for bus once trim changed
// [RL9] software keeps the trim within 0..31
// [RL10] writing one to bit 5 stops the oscillator
// [RL11] stopped oscillator restarts on usb activity or matching vbus
// [RL12] activity while suspended raises a resume interrupt
// [RL13] software re-enables the transceiver after the resume interrupt
// [RL14] bit 7 enables the oscillator when one, disables when zero
// [RL15] bit 6 reads one only while running at programmed frequency
// [RL16] control bits 4..2 read zero and ignore writes
// [RL17] trim bits 7..5 ignore writes; trim undefined under clock recovery
// [RL18] divide change never produces a shortened core clock period
`timescale 1ns/1ps
`include "ioc_map.svh"
module ioc_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic usb_nonidle,
  input wire logic vbus_level,
  input wire logic bus_power_polarity_sel,
  input wire logic clk_recovery_en,
  input wire logic [4:0] recovery_trim,
  input wire logic src_load,
  input wire logic [1:0] core_src_req,
  input wire logic [1:0] bus_src_req,
  input wire logic ext_osc_in,
  input wire logic mult_in,
  output logic osc_run,
  output logic [4:0] period_trim_value,
  output logic core_clock_tick,
  output logic bus_function_clock_tick,
  output logic resume_irq,
  output logic trim_modified
);
  ioc_div_if dif ();

  logic osc_run_enable_q;
  logic suspend_q;
  ioc_pkg::ioc_div_e core_clock_divide_sel_q;
  logic [4:0] trim_q;
  ioc_pkg::ioc_state_e st_q, st_d;
  logic [`IOC_SETTLE_W-1:0] settle_q;
  ioc_pkg::ioc_src_e core_src_q, bus_src_q;
  logic [7:0] rdata_q;
  logic [1:0] nonidle_q, vbus_q;
  logic [2:0] ext_q, mult_q;
  logic mult_half_q;
  logic core_tick_q, bus_tick_q, resume_q;
  logic ctrl_wr, trim_wr, wake, nonidle_s, ext_edge, mult_edge;
  logic osc_freq_ready;

  assign ctrl_wr = sfr_wr && sfr_addr == `IOC_CTRL_ADDR;
  assign trim_wr = sfr_wr && sfr_addr == `IOC_TRIM_ADDR;

  // pins: two flops, then a third only for edge detection
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nonidle_q <= 2'h0;
      vbus_q <= 2'h0;
      ext_q <= 3'h0;
      mult_q <= 3'h0;
    end else begin
      nonidle_q <= {nonidle_q[0], usb_nonidle};
      vbus_q <= {vbus_q[0], vbus_level};
      ext_q <= {ext_q[1:0], ext_osc_in};
      mult_q <= {mult_q[1:0], mult_in};
    end
  end

  assign nonidle_s = nonidle_q[1];
  assign ext_edge = ext_q[1] && !ext_q[2];
  assign mult_edge = mult_q[1] && !mult_q[2];
  assign wake = nonidle_s ||
    (vbus_q[1] == bus_power_polarity_sel); // [RL11]

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_run_enable_q <= 1'(`IOC_CTRL_RESET >> `IOC_EN_BIT); // [RL5]
      core_clock_divide_sel_q <= ioc_pkg::IOC_DIV8; // [RL5]
    end else if (ctrl_wr) begin
      osc_run_enable_q <= sfr_wdata[`IOC_EN_BIT]; // [RL14]
      core_clock_divide_sel_q <=
        ioc_pkg::ioc_div_e'(sfr_wdata[`IOC_DIV_MSB:0]); // [RL4]
    end
  end

  // a suspend write in the same cycle as a wake wins: software asked last
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      suspend_q <= 1'b0;
    end else if (ctrl_wr && sfr_wdata[`IOC_SUSP_BIT]) begin
      suspend_q <= 1'b1; // [RL10]
    end else if (st_q == ioc_pkg::IOC_SUSP && wake) begin
      suspend_q <= 1'b0; // [RL11]
    end
  end

  // upper trim bits are never stored; recovery owns the trim when on
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trim_q <= `IOC_TRIM_FACTORY; // [RL7]
    end else if (clk_recovery_en) begin
      trim_q <= recovery_trim; // [RL17]
    end else if (trim_wr) begin
      trim_q <= sfr_wdata[`IOC_TRIM_MSB:0]; // [RL6]
    end
  end

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ioc_pkg::IOC_OFF: begin
        if (osc_run_enable_q) begin
          st_d = ioc_pkg::IOC_SETTLE;
        end
      end
      ioc_pkg::IOC_SETTLE: begin
        if (suspend_q) begin
          st_d = ioc_pkg::IOC_SUSP;
        end else if (settle_q == `IOC_SETTLE_W'(`IOC_SETTLE_CYC - 1)) begin
          st_d = ioc_pkg::IOC_READY;
        end
      end
      ioc_pkg::IOC_READY: begin
        if (suspend_q) begin
          st_d = ioc_pkg::IOC_SUSP;
        end else if (trim_wr || clk_recovery_en) begin
          st_d = ioc_pkg::IOC_SETTLE; // [RL15]
        end
      end
      ioc_pkg::IOC_SUSP: begin
        if (wake) begin
          st_d = ioc_pkg::IOC_SETTLE; // [RL11]
        end
      end
    endcase
    if (!osc_run_enable_q) begin
      st_d = ioc_pkg::IOC_OFF; // [RL14]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ioc_pkg::IOC_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      settle_q <= '0;
    end else if (st_q == ioc_pkg::IOC_SETTLE && st_d == st_q) begin
      settle_q <= settle_q + `IOC_SETTLE_W'(1);
    end else begin
      settle_q <= '0;
    end
  end

  assign osc_run = st_q == ioc_pkg::IOC_SETTLE ||
    st_q == ioc_pkg::IOC_READY; // [RL10]
  assign osc_freq_ready = st_q == ioc_pkg::IOC_READY; // [RL15]

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      resume_q <= 1'b0;
    end else begin
      resume_q <= st_q == ioc_pkg::IOC_SUSP && nonidle_s; // [RL12]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd && sfr_addr == `IOC_CTRL_ADDR) begin
      rdata_q <= {osc_run_enable_q, osc_freq_ready, suspend_q, 3'h0,
        core_clock_divide_sel_q}; // [RL16]
    end else if (sfr_rd && sfr_addr == `IOC_TRIM_ADDR) begin
      rdata_q <= {3'h0, trim_q}; // [RL17]
    end else if (sfr_rd) begin
      rdata_q <= 8'h00;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_src_q <= ioc_pkg::IOC_SRC_INT; // [RL1]
      bus_src_q <= ioc_pkg::IOC_SRC_INT;
    end else if (src_load) begin
      core_src_q <= ioc_pkg::ioc_src_e'(core_src_req);
      bus_src_q <= ioc_pkg::ioc_src_e'(bus_src_req);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mult_half_q <= 1'b0;
    end else if (mult_edge) begin
      mult_half_q <= !mult_half_q;
    end
  end

  assign dif.run = osc_run;
  assign dif.sel = core_clock_divide_sel_q;
  ioc_clkdiv u_div (
    .clk(clk),
    .resetn(resetn),
    .dif(dif)
  );

  // an unused fourth source code yields no clock rather than a guess
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_tick_q <= 1'b0;
      bus_tick_q <= 1'b0;
    end else begin
      unique case (core_src_q)
        ioc_pkg::IOC_SRC_INT: core_tick_q <= dif.tick; // [RL2]
        ioc_pkg::IOC_SRC_EXT: core_tick_q <= ext_edge; // [RL2]
        ioc_pkg::IOC_SRC_MULT: core_tick_q <= mult_edge && mult_half_q;
        default: core_tick_q <= 1'b0;
      endcase
      unique case (bus_src_q)
        ioc_pkg::IOC_SRC_INT: bus_tick_q <= osc_run; // [RL3]
        ioc_pkg::IOC_SRC_EXT: bus_tick_q <= ext_edge; // [RL3]
        ioc_pkg::IOC_SRC_MULT: bus_tick_q <= mult_edge; // [RL3]
        default: bus_tick_q <= 1'b0;
      endcase
    end
  end

  assign sfr_rdata = rdata_q;
  assign period_trim_value = trim_q;
  assign core_clock_tick = core_tick_q;
  assign bus_function_clock_tick = bus_tick_q;
  assign resume_irq = resume_q;
  // lets software honour the bus clock restriction after retrimming
  assign trim_modified = trim_q != `IOC_TRIM_FACTORY; // [RL8]

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_CTRL_ZERO_BITS: assert property ( // [RL16]
    sfr_rd && sfr_addr == `IOC_CTRL_ADDR |=> sfr_rdata[4:2] == 3'h0)
    else $error("control unused bits not zero");
  AST_SUSPEND_STOPS: assert property ( // [RL10]
    ctrl_wr && sfr_wdata[`IOC_SUSP_BIT] |=> ##1 !osc_run)
    else $error("suspend write did not stop oscillator");
  AST_DISABLE_STOPS: assert property ( // [RL14]
    ctrl_wr && !sfr_wdata[`IOC_EN_BIT] |=> ##1 !osc_run [*2])
    else $error("disable did not stop oscillator");
  AST_WAKE_RESTART: assert property ( // [RL11]
    st_q == ioc_pkg::IOC_SUSP && wake && osc_run_enable_q && !ctrl_wr
      |=> osc_run)
    else $error("wake did not restart oscillator");
  AST_RESUME_IRQ: assert property ( // [RL12]
    st_q == ioc_pkg::IOC_SUSP && nonidle_s |=> resume_irq ##1 !resume_irq)
    else $error("resume interrupt missing or stuck");
  AST_READY_AFTER_SETTLE: assert property ( // [RL15]
    $rose(osc_freq_ready) |-> $past(st_q, 1) == ioc_pkg::IOC_SETTLE &&
      $past(osc_run, 10))
    else $error("ready before settling");
  AST_TRIM_WRITE: assert property ( // [RL6]
    trim_wr && !clk_recovery_en |=> period_trim_value == $past(sfr_wdata[4:0]))
    else $error("trim write not stored");
  AST_READ_DIV: assert property ( // [RL4]
    sfr_rd && sfr_addr == `IOC_CTRL_ADDR |=>
      sfr_rdata[1:0] == $past(core_clock_divide_sel_q))
    else $error("divide field read back wrong");
  AST_DIV_AT_TICK: assert property ( // [RL18]
    $changed(dif.applied) && $past(osc_run) |-> dif.tick)
    else $error("divide applied away from a period end");
endmodule
